// [src/sft_cfg.svh]
// constants for the single-edge nibble transmitter
`ifndef SFT_CFG_SVH
`define SFT_CFG_SVH
`define SFT_CFG_ADDR        4'h7
`define SFT_STAT_ADDR       4'h8
`define SFT_DATA_ADDR       4'h9
`define SFT_CFG_RESET       18'h00000
`define SFT_TICK_HI         17
`define SFT_TICK_LO         11
`define SFT_FIX_HI          10
`define SFT_FIX_LO          9
`define SFT_UPD_HI          7
`define SFT_UPD_LO          5
`define SFT_NIB_HI          4
`define SFT_NIB_LO          3
`define SFT_SER_HI          1
`define SFT_SER_LO          0
`define SFT_REF_HZ          4000000
`define SFT_CLK_HZ          125000000
`define SFT_TICK_DEFAULT    7'h0C
`define SFT_SYNC_TICKS      8'h38
`define SFT_NIB_BASE        8'h0C
`define SFT_TRIG_LOW_TICKS  8'h02
`define SFT_TRIG_HIGH_TICKS 8'h06
`define SFT_FIX_BASE        8'h03
`define SFT_CRC_SEED        4'h5
`endif

// [src/sft_crc4.sv]
// four-bit nibble checksum step
`timescale 1ns/1ps
`default_nettype none
module sft_crc4
  import sft_pkg::*;
(
  input  wire logic [3:0] crc_in,  // running checksum
  input  wire logic [3:0] nib,     // nibble folded in
  output logic      [3:0] crc_out  // next checksum
);
  // polynomial x^4+x^3+x^2+1, msb first per nibble
  function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [3:0] d);
    logic [3:0] r;
    logic       fb;
    r = c;
    for (int i = 3; i >= 0; i--) begin
      fb = r[3] ^ d[i];
      r  = {r[2:0], 1'b0};
      if (fb) begin
        r = r ^ 4'hD;
      end
    end
    return r;
  endfunction

  assign crc_out = crc_step(crc_in, nib);
endmodule
`default_nettype wire

// [src/sft_pkg.sv]
// types for the single-edge nibble transmitter
package sft_pkg;
  typedef enum logic [2:0] {
    SFT_IDLE = 3'b000,
    SFT_TRIG = 3'b001,
    SFT_GAP  = 3'b010,
    SFT_SYNC = 3'b011,
    SFT_NIB  = 3'b100
  } sft_state_t;
endpackage

// [src/sft_tick_gen.sv]
// tick pulse generator from a 4 MHz reference count
`timescale 1ns/1ps
`default_nettype none
`include "sft_cfg.svh"
module sft_tick_gen
  import sft_pkg::*;
(
  input  wire logic       core_clk, // system clock
  input  wire logic       nrst,     // sync reset, low active
  input  wire logic [6:0] div_code, // tick divider code
  output logic            tick      // one-cycle tick pulse
);
  // fractional accumulator gives an exact 4 MHz average
  logic [27:0] acc_r;
  logic [27:0] acc_sum;
  logic        ref_p;
  logic [6:0]  ref_cnt_r;
  logic [6:0]  div_eff;

  assign acc_sum = acc_r + 28'(`SFT_REF_HZ);
  assign ref_p   = (acc_sum >= 28'(`SFT_CLK_HZ));
  assign div_eff = (div_code == 7'h00) ? `SFT_TICK_DEFAULT : div_code;
  assign tick    = ref_p && (ref_cnt_r >= div_eff - 7'h01);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      acc_r <= 28'h0000000;
    end else if (ref_p) begin
      acc_r <= acc_sum - 28'(`SFT_CLK_HZ);
    end else begin
      acc_r <= acc_sum;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ref_cnt_r <= 7'h00;
    end else if (tick) begin
      ref_cnt_r <= 7'h00;
    end else if (ref_p) begin
      ref_cnt_r <= ref_cnt_r + 7'h01;
    end
  end

  property p_tick_rate;
    @(posedge core_clk) disable iff (!nrst)
      tick |=> !tick [*8];
  endproperty
  a_tick_rate: assert property (p_tick_rate)
    else $error("ticks closer than allowed");
endmodule
`default_nettype wire

// [src/sft_tx.sv]
// single-edge nibble transmitter with host trigger
// Function
// - tick rate is the 4 MHz count divided by the divider code, 12 for code 0
// - divider sits in config bits 17:11; code 1 is shortest tick
// - fixed low field bits 10:9; code 1 gives 4 low ticks
// - nibble count field bits 4:3 selects data nibbles per message
// - update field bits 7:5; 0 sends back to back, no pause
// - serial mode bits 1:0; stored only, no serial channel in any mode
// - order: 56-tick sync, status nibble, data, crc; nibble max 27
// - triggered only for update 3 or 4; idle until trigger
// - after trigger, wait 6 high ticks then transmit
// - sample data latched at end of status nibble except for update 3 or 4, which send the sample held at trigger
// - update 3 takes data at trigger start, 4 at trigger end
`timescale 1ns/1ps
`default_nettype none
`include "sft_cfg.svh"
module sft_tx
  import sft_pkg::*;
(
  input  wire logic        core_clk,   // 125 MHz clock
  input  wire logic        nrst,       // sync reset, low active
  input  wire logic [3:0]  reg_addr,   // register address
  input  wire logic [31:0] reg_wdata,  // write data
  input  wire logic        reg_wr,     // write strobe
  input  wire logic        reg_rd,     // read strobe
  output logic      [31:0] reg_rdata,  // read data, cycle after strobe
  input  wire logic [23:0] sample,     // sensor sample, six nibbles
  input  wire logic [3:0]  status_nib, // status and comm nibble
  input  wire logic        line_in,    // sensed level of output wire
  output logic             line_out,   // always low when driving
  output logic             line_oe_n   // low while pulling wire low
);
  logic [17:0]  cfg_r;
  logic [31:0]  rdata_r;
  sft_state_t   st_r;
  logic         tick;
  logic         l1_r, l2_r;
  logic [7:0]   tcnt_r;
  logic [7:0]   nib_len_r;
  logic [2:0]   idx_r;
  logic [23:0]  tx_data_r;
  logic [23:0]  hold_r;
  logic [3:0]   crc_r;
  logic [3:0]   crc_nxt;
  logic [3:0]   cur_nib;
  logic [2:0]   ndata;
  logic [7:0]   fix_ticks;
  logic [2:0]   upd;
  logic         trig_mode;
  logic         drive_low_r;
  logic [7:0]   len_of;
  logic [3:0]   crc_nib;

  assign upd       = cfg_r[`SFT_UPD_HI:`SFT_UPD_LO];
  assign trig_mode = (upd == 3'h3) || (upd == 3'h4);
  assign fix_ticks = `SFT_FIX_BASE + 8'(cfg_r[`SFT_FIX_HI:`SFT_FIX_LO]);
  assign ndata     = 3'h3 + 3'(cfg_r[`SFT_NIB_HI:`SFT_NIB_LO]);

  sft_tick_gen u_tick (
    .core_clk (core_clk),
    .nrst     (nrst),
    .div_code (cfg_r[`SFT_TICK_HI:`SFT_TICK_LO]),
    .tick     (tick)
  );

  // nibble 0 status, 1..n data, n+1 crc
  always_comb begin
    if (idx_r == 3'h0) begin
      cur_nib = status_nib;
    end else if (idx_r > ndata) begin
      cur_nib = crc_r;
    end else begin
      cur_nib = tx_data_r[4*(6-idx_r) +: 4];
    end
  end

  // zero step at status nibble advances the seed before the data
  assign crc_nib = (idx_r == 3'h0) ? 4'h0 : cur_nib;

  sft_crc4 u_crc (
    .crc_in  (crc_r),
    .nib     (crc_nib),
    .crc_out (crc_nxt)
  );

  assign len_of = `SFT_NIB_BASE + 8'(cur_nib);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      l1_r <= 1'b1;
      l2_r <= 1'b1;
    end else begin
      l1_r <= line_in;
      l2_r <= l1_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cfg_r <= `SFT_CFG_RESET;
    end else if (reg_wr && reg_addr == `SFT_CFG_ADDR) begin
      cfg_r <= reg_wdata[17:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata_r <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SFT_CFG_ADDR:  rdata_r <= {14'h0000, cfg_r};
        `SFT_STAT_ADDR: rdata_r <= {27'h0000000, l2_r, trig_mode, st_r};
        `SFT_DATA_ADDR: rdata_r <= {8'h00, tx_data_r};
        default:        rdata_r <= 32'h00000000;
      endcase
    end else begin
      rdata_r <= 32'h00000000;
    end
  end
  assign reg_rdata = rdata_r;

  // sample held at trigger start (mode 3) or trigger end (mode 4)
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hold_r <= 24'h000000;
    end else if (st_r == SFT_IDLE && !l2_r && upd == 3'h3) begin
      hold_r <= sample;
    end else if (st_r == SFT_TRIG && l2_r && upd == 3'h4) begin
      hold_r <= sample;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_r        <= SFT_IDLE;
      tcnt_r      <= 8'h00;
      nib_len_r   <= 8'h00;
      idx_r       <= 3'h0;
      tx_data_r   <= 24'h000000;
      crc_r       <= `SFT_CRC_SEED;
      drive_low_r <= 1'b0;
    end else begin
      case (st_r)
        SFT_IDLE: begin
          tcnt_r <= 8'h00;
          if (!trig_mode) begin
            st_r        <= SFT_SYNC;
            drive_low_r <= 1'b1;
          end else if (!l2_r) begin
            st_r <= SFT_TRIG;
          end
        end
        SFT_TRIG: begin
          if (l2_r) begin
            st_r   <= (tcnt_r >= `SFT_TRIG_LOW_TICKS) ? SFT_GAP : SFT_IDLE;
            tcnt_r <= 8'h00;
          end else if (tick && tcnt_r != 8'hFF) begin
            tcnt_r <= tcnt_r + 8'h01;
          end
        end
        SFT_GAP: begin
          if (!l2_r) begin
            st_r <= SFT_TRIG;
            tcnt_r <= 8'h00;
          end else if (tick) begin
            if (tcnt_r == `SFT_TRIG_HIGH_TICKS - 8'h01) begin
              st_r        <= SFT_SYNC;
              tcnt_r      <= 8'h00;
              drive_low_r <= 1'b1;
            end else begin
              tcnt_r <= tcnt_r + 8'h01;
            end
          end
        end
        SFT_SYNC: begin
          if (tick) begin
            if (tcnt_r == fix_ticks - 8'h01) begin
              drive_low_r <= 1'b0;
            end
            if (tcnt_r == `SFT_SYNC_TICKS - 8'h01) begin
              st_r        <= SFT_NIB;
              tcnt_r      <= 8'h00;
              idx_r       <= 3'h0;
              crc_r       <= `SFT_CRC_SEED;
              nib_len_r   <= `SFT_NIB_BASE + 8'(status_nib);
              drive_low_r <= 1'b1;
            end else begin
              tcnt_r <= tcnt_r + 8'h01;
            end
          end
        end
        SFT_NIB: begin
          if (tick) begin
            if (tcnt_r == fix_ticks - 8'h01) begin
              drive_low_r <= 1'b0;
            end
            if (tcnt_r == nib_len_r - 8'h01) begin
              tcnt_r <= 8'h00;
              if (idx_r == 3'h0) begin
                // latch point at end of status nibble
                tx_data_r <= trig_mode ? hold_r : sample;
                idx_r     <= 3'h1;
                crc_r     <= crc_nxt;
                nib_len_r <= `SFT_NIB_BASE + 8'(trig_mode ? hold_r[23:20] : sample[23:20]);
                drive_low_r <= 1'b1;
              end else if (idx_r > ndata) begin
                st_r        <= SFT_IDLE;
                drive_low_r <= !trig_mode;
                if (!trig_mode) begin
                  st_r   <= SFT_SYNC;
                end
              end else begin
                crc_r       <= crc_nxt;
                idx_r       <= idx_r + 3'h1;
                drive_low_r <= 1'b1;
                if (idx_r == ndata) begin
                  nib_len_r <= `SFT_NIB_BASE + 8'(crc_nxt);
                end else begin
                  nib_len_r <= `SFT_NIB_BASE + 8'(tx_data_r[4*(5-idx_r) +: 4]);
                end
              end
            end else begin
              tcnt_r <= tcnt_r + 8'h01;
            end
          end
        end
        default: begin
          st_r <= SFT_IDLE;
        end
      endcase
    end
  end

  assign line_out  = 1'b0;
  assign line_oe_n = !drive_low_r;

  // serial channel field is stored only; mode 0 adds nothing to status
  sequence s_trig_long;
    st_r == SFT_TRIG && l2_r && tcnt_r >= `SFT_TRIG_LOW_TICKS;
  endsequence

  sequence s_trig_short;
    st_r == SFT_TRIG && l2_r && tcnt_r < `SFT_TRIG_LOW_TICKS;
  endsequence

  sequence s_gap_end;
    st_r == SFT_GAP ##1 st_r == SFT_SYNC;
  endsequence

  property p_nib_max;
    @(posedge core_clk) disable iff (!nrst)
      st_r == SFT_NIB |-> nib_len_r <= 8'h1B;
  endproperty
  a_nib_max: assert property (p_nib_max)
    else $error("nibble over 27 ticks");

  property p_nib_len;
    @(posedge core_clk) disable iff (!nrst)
      (st_r == SFT_NIB && idx_r != 3'h0) |-> nib_len_r == len_of;
  endproperty
  a_nib_len: assert property (p_nib_len)
    else $error("nibble length differs from 12 plus value");

  property p_cont_next;
    @(posedge core_clk) disable iff (!nrst)
      (!trig_mode && st_r == SFT_IDLE) |=> st_r == SFT_SYNC;
  endproperty
  a_cont_next: assert property (p_cont_next)
    else $error("continuous mode paused between messages");

  property p_trig_idle;
    @(posedge core_clk) disable iff (!nrst)
      (trig_mode && st_r == SFT_IDLE && $stable(cfg_r)) |-> line_oe_n;
  endproperty
  a_trig_idle: assert property (p_trig_idle)
    else $error("driving line without trigger");

  property p_trig_short;
    @(posedge core_clk) disable iff (!nrst)
      s_trig_short |=> st_r == SFT_IDLE;
  endproperty
  a_trig_short: assert property (p_trig_short)
    else $error("short trigger pulse accepted");

  property p_trig_long;
    @(posedge core_clk) disable iff (!nrst)
      s_trig_long |=> st_r == SFT_GAP;
  endproperty
  a_trig_long: assert property (p_trig_long)
    else $error("valid trigger did not start the gap");

  property p_gap_start;
    @(posedge core_clk) disable iff (!nrst)
      s_gap_end |-> !line_oe_n;
  endproperty
  a_gap_start: assert property (p_gap_start)
    else $error("sync not started after gap");
endmodule
`default_nettype wire

// [tb/sft_host.sv]
// host model: pulled-up wire, trigger requests, edge time stamps
`timescale 1ns/1ps
`default_nettype none
module sft_host (
  input  wire logic core_clk,  // system clock
  input  wire logic line_out,  // device drive level
  input  wire logic line_oe_n, // device pulls when low
  output logic      line_in    // wire level seen by all
);
  logic host_low = 1'b0;
  logic prev     = 1'b1;
  int   cyc      = 0;
  int   fall_q[$];
  int   rise_q[$];
  // pull-up wins unless someone pulls low
  assign line_in = (line_oe_n | line_out) & ~host_low;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    prev <= line_in;
    if (prev & ~line_in) fall_q.push_back(cyc);
    if (~prev & line_in) rise_q.push_back(cyc);
  end
  // trigger request: pull low, later release
  task automatic drive(input logic v);
    @(posedge core_clk);
    host_low <= v;
  endtask
  task automatic clear();
    @(negedge core_clk);
    fall_q.delete();
    rise_q.delete();
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the nibble transmitter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk;
  logic        nrst;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [23:0] sample;
  logic [3:0]  status_nib;
  logic        line_in;
  logic        line_out;
  logic        line_oe_n;
  int          fails = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          f[$];
  sft_tx dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample(sample),
    .status_nib(status_nib), .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n));
  sft_host host (.core_clk(core_clk), .line_out(line_out), .line_oe_n(line_oe_n),
    .line_in(line_in));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails = fails + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("read data", reg_rdata, exp);
  endtask
  // ticks from cycles at the 0.25 us tick
  function automatic int tk(input int c);
    return (c * 4 + 62) / 125;
  endfunction
  function automatic logic [3:0] tbl(input logic [3:0] x);
    logic [7:0] r;
    r = {x, 4'h0};
    for (int b = 7; b > 3; b--)
      if (r[b]) r = r ^ (8'h1D << (b - 4));
    return r[3:0];
  endfunction
  function automatic logic [3:0] crc4(input logic [11:0] d);
    logic [3:0] c;
    c = 4'h5;
    for (int i = 0; i < 3; i++)
      c = tbl(c) ^ d[11 - 4 * i -: 4];
    return tbl(c);
  endfunction
  function automatic logic [31:0] cfg(input logic [6:0] t, input logic [1:0] x,
                                      input logic [2:0] u);
    return {14'h0000, t, x, 1'b0, u, 2'b00, 1'b0, 2'b00};
  endfunction
  // sync, status and three data nibbles from fall index i
  task automatic chk_msg(input int i, input logic [11:0] d);
    f = host.fall_q;
    chk("sync", 32'(tk(f[i + 1] - f[i])), 32'h38);
    chk("status", 32'(tk(f[i + 2] - f[i + 1])), 32'h15);
    for (int k = 0; k < 3; k++)
      chk("data", 32'(tk(f[i + 3 + k] - f[i + 2 + k])), 32'(12 + d[11 - 4 * k -: 4]));
  endtask
  task automatic t_reset();
    int d;
    rd(4'h7, 32'h0);
    for (int i = 0; i < 30000 && host.fall_q.size() < 2; i++) @(posedge core_clk);
    d = host.fall_q[1] - host.fall_q[0];
    chk("default sync", 32'(d >= 20998 && d <= 21002), 32'h1);
  endtask
  task automatic t_regs();
    wr(4'h7, 32'hFFFFFFFF);
    rd(4'h7, 32'h0003FFFF);
    wr(4'hF, 32'h00000000);
    rd(4'h7, 32'h0003FFFF);
    rd(4'hF, 32'h0);
  endtask
  task automatic t_trig(input logic [2:0] u);
    int g;
    wr(4'h7, cfg(7'h01, 2'h1, u));
    sample <= 24'h5A3000;
    repeat (8000) @(posedge core_clk);
    host.clear();
    repeat (2000) @(posedge core_clk);
    chk("idle falls", 32'(host.fall_q.size()), 32'h0);
    host.drive(1'b1);
    repeat (20) @(posedge core_clk);
    host.drive(1'b0);
    repeat (400) @(posedge core_clk);
    chk("short trigger", 32'(host.fall_q.size()), 32'h1);
    host.drive(1'b1);
    repeat (35) @(posedge core_clk);
    sample <= 24'hC71000;
    repeat (35) @(posedge core_clk);
    host.drive(1'b0);
    @(posedge core_clk);
    g = host.cyc;
    host.clear();
    repeat (8000) @(posedge core_clk);
    f = host.fall_q;
    chk("falls", 32'(f.size()), 32'h6);
    chk("gap", 32'(f[0] - g > 156 && f[0] - g <= 200), 32'h1);
    chk("low", 32'(tk(host.rise_q[0] - f[0])), 32'h4);
    chk_msg(0, (u == 3'h3) ? 12'h5A3 : 12'hC71);
    rd(4'h8, 32'h00000018);
    rd(4'h9, (u == 3'h3) ? 32'h005A3000 : 32'h00C71000);
  endtask
  task automatic t_cont();
    int i;
    int o;
    wr(4'h7, cfg(7'h01, 2'h2, 3'h0));
    repeat (2000) @(posedge core_clk);
    host.clear();
    repeat (14000) @(posedge core_clk);
    f = host.fall_q;
    for (i = 0; i < 6 && tk(f[i + 1] - f[i]) != 56; i++) @(posedge core_clk);
    chk_msg(i, 12'hC71);
    f = host.fall_q;
    o = (host.rise_q[0] < f[0]) ? 1 : 0;
    chk("low", 32'(tk(host.rise_q[i + o] - f[i])), 32'h5);
    chk("crc", 32'(tk(f[i + 6] - f[i + 5])), 32'(12 + crc4(12'hC71)));
    chk("next sync", 32'(tk(f[i + 7] - f[i + 6])), 32'h38);
  endtask
  initial begin
    nrst = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sample = 24'h000000;
    status_nib = 4'h9;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_trig(3'h3);
    t_trig(3'h4);
    t_cont();
    end_of_test();
  end
endmodule
`default_nettype wire
